// >>> verilog/seep_pkg.sv
// Constants and types for the two-wire serial EEPROM engine.
// Assumes a 25 MHz system clock sampling SCL and SDA as plain inputs.
// Operation
// - After write device address, word address bytes are taken and acknowledged low.
// - Each received write data byte is acknowledged by pulling SDA low.
// - Stop after a write starts the self-timed programming cycle.
// - While programming runs, bus inputs are ignored and nothing answers.
// - A page write carries at most 32 bytes in one sequence.
// - Each write byte increments only the low five address bits.
// - In-page address wraps to the page start; extra bytes overwrite.
// - Polling gets an acknowledge only once programming has finished.
// - Direction bit one in the device address selects a read.
// - Address counter holds last address plus one between operations.
// - Read counter wraps from array end to address zero.
// - After read address acknowledge, data byte goes out MSB first.
// - Counter advances after each read byte's last bit; controller acknowledge sends next.
// - Programming completes within 5 ms of the stop.
// - Write-protect high inhibits all array writes.
// - Word address is 12 bits or 13 bits depending on array size.
// - Only a matching chip-select field is answered; mismatch goes to standby.
package seep_pkg;
  localparam int unsigned CLK_HZ           = 25_000_000;
  localparam int unsigned PROG_TIME_MS     = 5;
  localparam int unsigned PROG_CYCLES      = CLK_HZ / 1000 * PROG_TIME_MS;
  localparam int unsigned ADDR_W           = 13;
  localparam int unsigned PAGE_W           = 5;
  localparam logic [3:0]  DEV_TYPE_CODE    = 4'ha;
  localparam logic [2:0]  BIT_LAST         = 3'h7;
  localparam logic [7:0]  BYTE_ZERO        = 8'h00;
  localparam logic [PAGE_W-1:0] PAGE_ONE   = 5'h01;

  typedef enum logic [2:0] {
    SEEP_IDLE, SEEP_DEV, SEEP_AHI, SEEP_ALO, SEEP_WDATA, SEEP_RDATA,
    SEEP_RACK, SEEP_WAIT
  } seep_state_type;
endpackage

// >>> verilog/seep_mem.sv
// Flip-flop storage array for the EEPROM engine.
// Assumes one write port and one combinational read port on clk.
`timescale 1ns/1ps
module seep_mem #(
  parameter int unsigned AW = 13
) (
  input  wire logic          clk,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [7:0]    wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [7:0]    rdata
);
  logic [7:0] store_reg [2**AW];

  always_ff @(posedge clk) begin
    if (we) begin
      store_reg[waddr] <= wdata;
    end
  end

  assign rdata = store_reg[raddr];
endmodule

// >>> verilog/seep_engine.sv
// Two-wire EEPROM target: byte/page write, polling, reads.
// Assumes SCL/SDA arrive asynchronously and the pad resolves sda_oe.
`timescale 1ns/1ps
module seep_engine #(
  parameter int unsigned PROG_CYCLES = seep_pkg::PROG_CYCLES,
  parameter bit          BIG_ARRAY   = 1'b1
) (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe,
  input  wire logic [2:0] chip_select_straps,
  input  wire logic       write_protect,
  output logic            busy
);
  localparam int unsigned AW = seep_pkg::ADDR_W;
  localparam int unsigned PW = seep_pkg::PAGE_W;
  localparam logic [AW-1:0] AMASK =
    BIG_ARRAY ? 13'h1fff : 13'h0fff;

  logic [1:0] scl_s_reg, sda_s_reg;
  logic       scl_d_reg, sda_d_reg;
  logic       scl, sda;
  assign scl = scl_s_reg[1];
  assign sda = sda_s_reg[1];

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_s_reg <= 2'h3;
      sda_s_reg <= 2'h3;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_s_reg <= {scl_s_reg[0], scl_i};
      sda_s_reg <= {sda_s_reg[0], sda_i};
      scl_d_reg <= scl;
      sda_d_reg <= sda;
    end
  end

  logic [1:0] wp_s_reg;
  logic [2:0] cs_s0_reg, cs_s1_reg;
  logic       wp_sync;
  assign wp_sync = wp_s_reg[1];

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wp_s_reg  <= 2'h0;
      cs_s0_reg <= 3'h0;
      cs_s1_reg <= 3'h0;
    end else begin
      wp_s_reg  <= {wp_s_reg[0], write_protect};
      cs_s0_reg <= chip_select_straps;
      cs_s1_reg <= cs_s0_reg;
    end
  end

  wire scl_rise = scl & ~scl_d_reg;
  wire scl_fall = ~scl & scl_d_reg;
  wire start_c  = scl & scl_d_reg & sda_d_reg & ~sda;
  wire stop_c   = scl & scl_d_reg & ~sda_d_reg & sda;

  seep_pkg::seep_state_type state_reg, state_next;
  logic [2:0]    bit_reg, bit_next;
  logic          ackph_reg, ackph_next;
  logic [7:0]    sh_reg, sh_next;
  logic [AW-1:0] addr_reg, addr_next;
  logic [7:0]    ahi_reg, ahi_next;
  logic          drv_reg, drv_next;
  logic          wrote_reg, wrote_next;
  logic          rd_reg, rd_next;
  logic [31:0]   prog_reg, prog_next;
  logic          we;
  logic [7:0]    rdata;

  wire [7:0] sh_in = {sh_reg[6:0], sda};
  wire dev_ok = sh_in[7:4] == seep_pkg::DEV_TYPE_CODE
    && sh_in[3:1] == cs_s1_reg;
  wire byte_done = scl_rise && !ackph_reg && bit_reg == seep_pkg::BIT_LAST;

  function automatic logic [AW-1:0] page_inc(input logic [AW-1:0] a);
    page_inc = {a[AW-1:PW], a[PW-1:0] + seep_pkg::PAGE_ONE};
  endfunction

  function automatic logic [AW-1:0] arr_inc(input logic [AW-1:0] a);
    arr_inc = (a + 13'h0001) & AMASK;
  endfunction

  seep_mem #(.AW(AW)) u_mem (
    .clk   (clk),
    .we    (we),
    .waddr (addr_reg),
    .wdata (sh_in),
    .raddr (addr_reg),
    .rdata (rdata)
  );

  assign we = byte_done && state_reg == seep_pkg::SEEP_WDATA
    && !wp_sync;
  assign busy   = state_reg == seep_pkg::SEEP_WAIT;
  assign sda_o  = 1'b0;
  assign sda_oe = drv_reg;

  always_comb begin
    state_next = state_reg;
    bit_next   = bit_reg;
    ackph_next = ackph_reg;
    sh_next    = sh_reg;
    addr_next  = addr_reg;
    ahi_next   = ahi_reg;
    drv_next   = drv_reg;
    wrote_next = wrote_reg;
    rd_next    = rd_reg;
    prog_next  = prog_reg;
    if (state_reg == seep_pkg::SEEP_WAIT) begin
      drv_next = 1'b0;
      if (prog_reg == 32'h0) begin
        state_next = seep_pkg::SEEP_IDLE;
      end else begin
        prog_next = prog_reg - 32'h1;
      end
    end else if (stop_c) begin
      drv_next = 1'b0;
      if (wrote_reg) begin
        state_next = seep_pkg::SEEP_WAIT;
        prog_next  = PROG_CYCLES - 1;
      end else begin
        state_next = seep_pkg::SEEP_IDLE;
      end
      wrote_next = 1'b0;
    end else if (start_c) begin
      drv_next   = 1'b0;
      state_next = seep_pkg::SEEP_DEV;
      bit_next   = 3'h0;
      ackph_next = 1'b0;
    end else if (state_reg != seep_pkg::SEEP_IDLE) begin
      if (scl_fall && ackph_reg && drv_reg) begin
        drv_next = 1'b0;
        ackph_next = 1'b0;
        bit_next = 3'h0;
        if (rd_reg) begin
          sh_next  = rdata;
          drv_next = ~rdata[7];
        end
      end else if (scl_fall && state_reg == seep_pkg::SEEP_RDATA
                   && !ackph_reg) begin
        drv_next = ~sh_reg[6];
        sh_next  = {sh_reg[6:0], 1'b0};
        if (bit_reg == seep_pkg::BIT_LAST) begin
          drv_next   = 1'b0;
          ackph_next = 1'b1;
          addr_next  = arr_inc(addr_reg);
          state_next = seep_pkg::SEEP_RACK;
        end else begin
          bit_next = bit_reg + 3'h1;
        end
      end else if (scl_fall && state_reg == seep_pkg::SEEP_RACK
                   && !ackph_reg) begin
        sh_next    = rdata;
        drv_next   = ~rdata[7];
        bit_next   = 3'h0;
        state_next = seep_pkg::SEEP_RDATA;
      end else if (scl_rise && state_reg == seep_pkg::SEEP_RACK) begin
        ackph_next = 1'b0;
        if (sda) begin
          state_next = seep_pkg::SEEP_IDLE;
        end
      end else if (scl_rise && !ackph_reg
                   && state_reg != seep_pkg::SEEP_RDATA) begin
        sh_next = sh_in;
        bit_next = bit_reg + 3'h1;
        if (bit_reg == seep_pkg::BIT_LAST) begin
          ackph_next = 1'b1;
          drv_next   = 1'b0;
          rd_next    = 1'b0;
          unique case (state_reg)
            seep_pkg::SEEP_DEV: begin
              if (dev_ok) begin
                rd_next    = sh_in[0];
                state_next = sh_in[0] ? seep_pkg::SEEP_RDATA
                                      : seep_pkg::SEEP_AHI;
              end else begin
                state_next = seep_pkg::SEEP_IDLE;
              end
            end
            seep_pkg::SEEP_AHI: begin
              ahi_next   = sh_in;
              state_next = seep_pkg::SEEP_ALO;
            end
            seep_pkg::SEEP_ALO: begin
              addr_next  = {ahi_reg[4:0], sh_in} & AMASK;
              state_next = seep_pkg::SEEP_WDATA;
            end
            seep_pkg::SEEP_WDATA: begin
              addr_next  = page_inc(addr_reg);
              wrote_next = 1'b1;
            end
            default: state_next = seep_pkg::SEEP_IDLE;
          endcase
        end
      end else if (scl_fall && ackph_reg && !drv_reg
                   && state_reg != seep_pkg::SEEP_IDLE) begin
        drv_next = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= seep_pkg::SEEP_IDLE;
      bit_reg   <= 3'h0;
      ackph_reg <= 1'b0;
      sh_reg    <= seep_pkg::BYTE_ZERO;
      addr_reg  <= '0;
      ahi_reg   <= seep_pkg::BYTE_ZERO;
      drv_reg   <= 1'b0;
      wrote_reg <= 1'b0;
      rd_reg    <= 1'b0;
      prog_reg  <= 32'h0;
    end else begin
      state_reg <= state_next;
      bit_reg   <= bit_next;
      ackph_reg <= ackph_next;
      sh_reg    <= sh_next;
      addr_reg  <= addr_next;
      ahi_reg   <= ahi_next;
      drv_reg   <= drv_next;
      wrote_reg <= wrote_next;
      rd_reg    <= rd_next;
      prog_reg  <= prog_next;
    end
  end

  logic [31:0] busy_len_reg;
  wire  [31:0] busy_len_next = busy ? busy_len_reg + 32'h1 : 32'h0;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      busy_len_reg <= 32'h0;
    end else begin
      busy_len_reg <= busy_len_next;
    end
  end

  a_busy_silent: assert property (
    @(posedge clk) disable iff (!arst_n) busy |=> !sda_oe)
    else $error("drove SDA while busy");
  a_wp_blocks: assert property (
    @(posedge clk) disable iff (!arst_n) wp_sync |-> !we)
    else $error("write under protect");
  a_page_keep: assert property (
    @(posedge clk) disable iff (!arst_n)
    we |=> addr_reg[AW-1:PW] == $past(addr_reg[AW-1:PW]))
    else $error("page row changed");
  a_page_wrap: assert property (
    @(posedge clk) disable iff (!arst_n)
    (we && addr_reg[PW-1:0] == '1) |=> addr_reg[PW-1:0] == '0)
    else $error("page address did not wrap");
  a_stop_prog: assert property (
    @(posedge clk) disable iff (!arst_n)
    (stop_c && wrote_reg && !busy) |=> busy)
    else $error("no program after stop");
  a_prog_ends: assert property (
    @(posedge clk) disable iff (!arst_n) $rose(busy) |-> busy[*8])
    else $error("program too short");
  a_prog_limit: assert property (
    @(posedge clk) disable iff (!arst_n)
    busy |-> busy_len_reg < PROG_CYCLES)
    else $error("program cycle overran");
  a_addr_range: assert property (
    @(posedge clk) disable iff (!arst_n) (addr_reg & ~AMASK) == '0)
    else $error("address out of array");
  a_addr_hold: assert property (
    @(posedge clk) disable iff (!arst_n)
    (state_reg == seep_pkg::SEEP_IDLE || busy) |=> $stable(addr_reg))
    else $error("address counter lost");
  a_stop_release: assert property (
    @(posedge clk) disable iff (!arst_n) stop_c |=> !sda_oe)
    else $error("SDA held after stop");
  a_ack_drive: assert property (
    @(posedge clk) disable iff (!arst_n)
    (scl_fall && ackph_reg && !drv_reg
     && state_reg inside {seep_pkg::SEEP_AHI, seep_pkg::SEEP_ALO,
                          seep_pkg::SEEP_WDATA, seep_pkg::SEEP_RDATA})
    |=> sda_oe)
    else $error("acknowledge not driven");
  a_rd_shift: assert property (
    @(posedge clk) disable iff (!arst_n)
    (state_reg == seep_pkg::SEEP_RDATA && !ackph_reg)
    |-> sda_oe == !sh_reg[7])
    else $error("read bit out of order");
  a_rd_wrap: assert property (
    @(posedge clk) disable iff (!arst_n)
    (scl_fall && state_reg == seep_pkg::SEEP_RDATA && !ackph_reg
     && bit_reg == seep_pkg::BIT_LAST && addr_reg == AMASK)
    |=> addr_reg == '0)
    else $error("read counter did not wrap");
  a_nak_end: assert property (
    @(posedge clk) disable iff (!arst_n)
    (scl_rise && state_reg == seep_pkg::SEEP_RACK && sda)
    |=> state_reg == seep_pkg::SEEP_IDLE)
    else $error("read went on after no acknowledge");
  a_nomatch_idle: assert property (
    @(posedge clk) disable iff (!arst_n)
    (byte_done && state_reg == seep_pkg::SEEP_DEV && !dev_ok && !start_c
     && !stop_c) |=> state_reg == seep_pkg::SEEP_IDLE)
    else $error("answered foreign address");
endmodule

// >>> tb/seep_ctl_model.sv
// Two-wire bus controller model for the EEPROM engine bench.
// Assumes SDA resolves with a pull-up; SCL rests high outside frames.
`timescale 1ns/1ps
module seep_ctl_model (
  input  wire logic clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_oe
);
  initial begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Data set in SCL low, sampled mid SCL high
  task automatic bit_io(input logic b, output logic r);
    sda_oe = ~b;
    wt(2);
    scl = 1'b1;
    wt(2);
    r = sda;
    wt(2);
    scl = 1'b0;
    wt(2);
  endtask
  // Start, also used as repeated start
  task automatic start();
    sda_oe = 1'b0;
    wt(2);
    scl = 1'b1;
    wt(4);
    sda_oe = 1'b1;
    wt(4);
    scl = 1'b0;
    wt(2);
  endtask
  task automatic stop();
    sda_oe = 1'b1;
    wt(2);
    scl = 1'b1;
    wt(2);
    sda_oe = 1'b0;
    wt(4);
  endtask
  task automatic byte_w(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 0; i < 8; i++) bit_io(d[7-i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  // Acknowledge low to continue, high to end the read
  task automatic byte_r(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 0; i < 8; i++) begin
      bit_io(1'b1, r);
      d[7-i] = r;
    end
    bit_io(~ack, r);
  endtask
endmodule

// >>> tb/test_serial_eeprom_rw_engine.sv
// Self-checking bench for the EEPROM engine.
// Assumes the controller model in seep_ctl_model and the seep_pkg package.
`timescale 1ns/1ps
module test_serial_eeprom_rw_engine;
  localparam int unsigned PC = 400;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [2:0] straps = 3'h0;
  logic wp = 1'b0;
  logic scl, m_oe, sda_o, sda_oe, busy;
  logic [7:0] mem_ref [8192];
  logic [12:0] ctr;
  logic [15:0] a;
  logic ack;
  int bad_count = 0;
  int comparisons = 0;
  wire sda = (sda_oe ? sda_o : 1'b1) & ~m_oe;
  always #20 clk = ~clk;
  seep_engine #(.PROG_CYCLES(PC), .BIG_ARRAY(1'b1)) seep_engine_i (
    .clk(clk), .arst_n(arst_n), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe(sda_oe), .chip_select_straps(straps), .write_protect(wp),
    .busy(busy));
  seep_ctl_model seep_ctl_model_i (
    .clk(clk), .sda(sda), .scl(scl), .sda_oe(m_oe));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("bad_count %0d comparisons %0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic dev(input logic rd, input logic [2:0] cs, output logic k);
    seep_ctl_model_i.start();
    seep_ctl_model_i.byte_w({seep_pkg::DEV_TYPE_CODE, cs, rd}, k);
  endtask
  task automatic set_addr(input logic [15:0] ad);
    dev(1'b0, straps, ack);
    check(ack, 1);
    seep_ctl_model_i.byte_w(ad[15:8], ack);
    check(ack, 1);
    seep_ctl_model_i.byte_w(ad[7:0], ack);
    check(ack, 1);
    ctr = ad[12:0];
  endtask
  task automatic wr(input logic [15:0] ad, input int n);
    logic [7:0] d;
    int k;
    set_addr(ad);
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      seep_ctl_model_i.byte_w(d, ack);
      check(ack, 1);
      if (!wp) mem_ref[ctr] = d;
      ctr = {ctr[12:5], ctr[4:0] + 5'h01};
    end
    seep_ctl_model_i.stop();
    seep_ctl_model_i.wt(2);
    check(busy, 1);
    dev(1'b0, straps, ack);
    check(ack, 0);
    seep_ctl_model_i.stop();
    k = 0;
    while (busy === 1'b1 && k < PC) begin
      seep_ctl_model_i.wt(1);
      k++;
    end
    check(busy, 0);
    if (busy !== 1'b0) end_sim();
    dev(1'b0, straps, ack);
    check(ack, 1);
    seep_ctl_model_i.stop();
  endtask
  task automatic rd(input int n);
    logic [7:0] d;
    dev(1'b1, straps, ack);
    check(ack, 1);
    for (int i = 0; i < n; i++) begin
      seep_ctl_model_i.byte_r(i < n - 1, d);
      check(d, mem_ref[ctr]);
      ctr = ctr + 13'h0001;
    end
    seep_ctl_model_i.stop();
  endtask
  initial begin
    void'($urandom(32'h8d677961));
    straps = 3'($urandom);
    repeat (10) @(negedge clk);
    arst_n = 1'b1;
    seep_ctl_model_i.wt(2);
    check(busy, 0);
    check(sda_oe, 0);
    wr(16'h0000, 1);
    wr(16'hffff, 1);
    set_addr(16'he1ff);
    set_addr(16'h1fff);
    rd(2);
    a = 16'($urandom) & 16'h1fef;
    wr(a, 34);
    set_addr({a[15:5], 5'h00});
    rd(31);
    rd(1);
    for (int i = 1; i < 8; i++) begin
      dev(1'b1, straps ^ 3'(i), ack);
      check(ack, 0);
      seep_ctl_model_i.stop();
    end
    wp = 1'b1;
    wr(a, 3);
    set_addr(a);
    rd(3);
    wp = 1'b0;
    end_sim();
  end
endmodule
